// *** dram_addr_mux.sv ***
`timescale 1ns/1ps
`include "dram_seq_map.svh"

module dram_addr_mux (
  // transfer address and bank setup
  input  wire logic [31:0]                   addr,
  input  wire dram_seq_pkg::page_size_t      page_size,
  input  wire dram_seq_pkg::port_size_t      port_size,
  // multiplexed address values
  output logic      [`DRAM_ADDR_W-1:0]       row_addr,
  output logic      [`DRAM_ADDR_W-1:0]       col_addr,
  output logic      [`PAGE_TAG_W-1:0]        page_tag
);
  import dram_seq_pkg::*;

  logic [10:0] page_mask;
  logic [10:0] page_off;
  logic [10:0] col_raw;

  // ========================================================
  // page offset bits, scaled by port width
  always_comb begin
    case (page_size)
      PAGE_1K: page_mask = 11'h3FF;
      PAGE_2K: page_mask = 11'h7FF;
      default: page_mask = 11'h1FF;
    endcase
  end

  assign page_off = addr[10:0] & page_mask;
  assign col_raw  = (port_size == PORT_8)  ? page_off :
                    (port_size == PORT_16) ? (page_off >> 1) : (page_off >> 2);
  assign row_addr = addr[27:`ROW_ADDR_LSB];
  assign col_addr = {8'h00, col_raw};
  // page tag keeps bits 31 down to 9, 10 or 11
  assign page_tag = addr[31:`ROW_ADDR_LSB] & {21'h1FFFFF, ~page_mask[10:9]};

endmodule // dram_addr_mux

// *** dram_model.sv ***
`timescale 1ns/1ps
module dram_model #(
  parameter logic [31:0] PAT = 32'hA5C3_5A3C
) (
  // strobes and bus
  input  wire logic [1:0]  ras_n,
  input  wire logic [3:0]  cas_n,
  input  wire logic [3:0]  d_oe,
  output logic      [31:0] d_in
);
  // drives only while row and column are open and the controller is off the bus;
  // a released bus shows the inverse, so a late sample cannot pass
  assign d_in = (ras_n != 2'h3 && cas_n != 4'hF && d_oe == 4'h0) ? PAT : ~PAT;
endmodule // dram_model

// *** dram_normal_mode_sequencer.sv ***
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "dram_seq_map.svh"
// Notes on behaviour
// - every transfer drives a new row then a new column address
// - row address, row strobe, column address, column strobe, then both negate
// - operand within port width is one nonburst access opened by transfer start
// - wait for the bank's precharge; another bank is not delayed
// - fastest nonburst takes three clocks plus 2.5 clocks precharge before the same bank; timing register slows
// - wider operand splits into port-wide segments, transfer start only once
// - each later burst segment waits out precharge after the previous one
// - fastest burst: three clocks first segment, four clocks each later one
// - size code 1 for byte, 0 for longword, from the first clock
// - write indicator high for reads, low for writes, from the first clock
// - fixed edge sequence: row, strobe, column, strobe, acknowledge, capture and negate
// - next nonburst to the same bank starts no earlier than the sixth edge
// - 8-bit port uses top byte lane and only the lowest column strobe
// - 16-bit burst write uses upper half and two low strobes, precharge between
// - after the last write segment the whole data bus is released
// - reads and writes share timing; only the data driver differs
// - page size alone selects the page address bits; port width only scales the column address
// - page size codes 0,1,2 compare bits 31 down to 9, 10, 11
// - size code 2 for a word operand

module dram_normal_mode_sequencer (
  // clock and reset
  input  wire  logic                       clk,
  input  wire  logic                       arst_n,
  // register port
  input  wire  logic [3:0]                 reg_addr,
  input  wire  logic [31:0]                reg_wdata,
  input  wire  logic                       reg_wr,
  input  wire  logic                       reg_rd,
  output logic       [31:0]                reg_rdata,
  // core request side
  input  wire  logic                       req,
  input  wire  logic                       req_bank,
  input  wire  logic [31:0]                req_addr,
  input  wire  logic                       req_write,
  input  wire  dram_seq_pkg::size_code_t   req_size,
  input  wire  logic [31:0]                req_wdata,
  output logic                             transfer_start_n,
  output logic                             transfer_ack_n,
  output logic [31:0]                      rd_data,
  output logic                             rd_valid,
  output logic                             busy,
  // dram pins
  output logic [`DRAM_ADDR_W-1:0]          dram_addr,
  output logic [1:0]                       ras_n,
  output logic [3:0]                       cas_n,
  output logic                             dram_write_indicator,
  output dram_seq_pkg::size_code_t         transfer_size_code,
  input  wire  logic [31:0]                d_in,
  output logic [31:0]                      d_out,
  output logic [3:0]                       d_oe
);
  import dram_seq_pkg::*;

  localparam int NBANK = 2;

  // ========================================================
  // declarations
  seq_state_t               state_r, state_nxt;
  logic [3:0]               bank_control_reg [NBANK];
  logic [5:0]               dram_timing_reg;
  logic [1:0]               wcnt_r;
  logic                     cur_bank_r;
  logic [31:0]              addr_r;
  logic                     write_r;
  logic [4:0]               segs_left_r;
  logic [1:0]               wbytes_r;
  logic [31:0]              wsh_r;
  logic [31:0]              rsh_r;
  logic [2:0]               prech_r [NBANK];
  logic [NBANK-1:0]         ras_hold_r, ras_fall_r;
  logic [3:0]               cas_hold_r, cas_fall_r;
  logic [`PAGE_TAG_W-1:0]   last_tag_r;
  logic                     page_hit_r;
  logic [31:0]              reg_rdata_r;
  logic                     ts_n_r, ack_n_r, rd_valid_r, busy_r, dwi_r;
  logic [31:0]              rd_data_r;
  logic [`DRAM_ADDR_W-1:0]  dram_addr_r;
  logic [3:0]               d_oe_r;
  size_code_t               size_r;

  // ========================================================
  // decode and selection
  wire         start_w     = (state_r == ST_IDLE) && req && (prech_r[req_bank] == 3'h0);
  wire         seg_end_w   = (state_r == ST_ACK);
  wire         last_seg_w  = (segs_left_r == 5'h01);
  wire         sel_bank_w  = (state_r == ST_IDLE) ? req_bank : cur_bank_r;
  wire  [1:0]  rcd_w       = dram_timing_reg[`TIM_RCD_LSB +: 2];
  wire  [1:0]  casw_w      = dram_timing_reg[`TIM_CAS_LSB +: 2];
  wire  [1:0]  rpx_w       = dram_timing_reg[`TIM_RP_LSB +: 2];
  wire  [2:0]  prech_load_w = `RP_BASE_CLKS + {1'b0, rpx_w};
  wire  [3:0]  sel_ctrl_w  = bank_control_reg[sel_bank_w];
  port_size_t  sel_port_w;
  page_size_t  sel_page_w;
  assign sel_port_w = port_size_t'(sel_ctrl_w[`CTRL_PORT_LSB +: 2]);
  assign sel_page_w = page_size_t'(sel_ctrl_w[`CTRL_PAGE_LSB +: 2]);

  logic [3:0]               cas_mask_w, lane_oe_w;
  logic [2:0]               port_bytes_w;
  logic [4:0]               seg_count_w;
  logic [31:0]              wr_shifted_w, rd_merged_w;
  logic [`DRAM_ADDR_W-1:0]  row_w, col_w;
  logic [`PAGE_TAG_W-1:0]   tag_w;

  wire  [31:0] addr_inc_w  = addr_r + {29'h0, port_bytes_w};
  wire  [31:0] addr_sel_w  = (state_r == ST_IDLE) ? req_addr : (seg_end_w ? addr_inc_w : addr_r);
  wire  [2:0]  wb_sum_w    = {1'b0, wbytes_r} + port_bytes_w;
  wire         word_done_w = wb_sum_w[2] || last_seg_w;
  wire         enter_row_w = (state_nxt == ST_ROW) && (state_r != ST_ROW);
  wire         enter_col_w = (state_nxt == ST_COL) && (state_r != ST_COL);
  wire         enter_pre_w = (state_nxt == ST_PRE) && (state_r != ST_PRE);

  wire         hit_bank0_w = (reg_addr == `REG_BANK0_CTRL);
  wire         hit_bank1_w = (reg_addr == `REG_BANK1_CTRL);
  wire         hit_tim_w   = (reg_addr == `REG_TIMING);
  wire         hit_stat_w  = (reg_addr == `REG_STATUS);
  wire  [31:0] rd_mux_w    = hit_bank0_w ? {28'h0, bank_control_reg[0]} :
                             hit_bank1_w ? {28'h0, bank_control_reg[1]} :
                             hit_tim_w   ? {26'h0, dram_timing_reg} :
                             hit_stat_w  ? {26'h0, page_hit_r, cur_bank_r, busy_r, state_r} : 32'h0;

  // ========================================================
  // helpers
  dram_addr_mux u_addr_mux (
    .addr      (addr_sel_w),
    .page_size (sel_page_w),
    .port_size (sel_port_w),
    .row_addr  (row_w),
    .col_addr  (col_w),
    .page_tag  (tag_w)
  );

  lane_steer u_lane (
    .port_size  (sel_port_w),
    .op_size    (req_size),
    .wr_word    (wsh_r),
    .rd_word    (rsh_r),
    .d_in       (d_in),
    .cas_mask   (cas_mask_w),
    .lane_oe    (lane_oe_w),
    .port_bytes (port_bytes_w),
    .seg_count  (seg_count_w),
    .wr_shifted (wr_shifted_w),
    .rd_merged  (rd_merged_w)
  );

  // ========================================================
  // state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start_w) begin
        state_nxt = ST_ROW;
      end
      ST_ROW:  if (wcnt_r == rcd_w) begin
        state_nxt = ST_COL;
      end
      ST_COL:  if (wcnt_r == casw_w) begin
        state_nxt = ST_ACK;
      end
      ST_ACK:  state_nxt = last_seg_w ? ST_IDLE : ST_PRE;
      // strobe asserts half a clock after this, which meets precharge
      ST_PRE:  if (prech_r[cur_bank_r] <= 3'h1) begin
        state_nxt = ST_ROW;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      wcnt_r  <= 2'h0;
    end else begin
      state_r <= state_nxt;
      wcnt_r  <= (state_nxt != state_r) ? 2'h0 : wcnt_r + 2'h1;
    end
  end

  // ========================================================
  // transfer context
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_bank_r  <= 1'b0;
      addr_r      <= 32'h0;
      write_r     <= 1'b0;
      segs_left_r <= 5'h00;
      wbytes_r    <= 2'h0;
      size_r      <= SZ_LONG;
      dwi_r       <= 1'b1;
      last_tag_r  <= '0;
      page_hit_r  <= 1'b0;
    end else if (start_w) begin
      cur_bank_r  <= req_bank;
      addr_r      <= req_addr;
      write_r     <= req_write;
      segs_left_r <= seg_count_w;
      wbytes_r    <= 2'h0;
      size_r      <= req_size;
      dwi_r       <= ~req_write;
      last_tag_r  <= tag_w;
      page_hit_r  <= (tag_w == last_tag_r);
    end else if (seg_end_w) begin
      addr_r      <= addr_inc_w;
      segs_left_r <= segs_left_r - 5'h01;
      wbytes_r    <= wb_sum_w[1:0];
    end
  end

  // ========================================================
  // per bank precharge tracking and row strobes
  genvar b;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      wire ctrl_wr_w = reg_wr && (reg_addr[3:2] == 2'(b));
      wire mine_w    = (cur_bank_r == 1'(b));

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          bank_control_reg[b] <= `CTRL_RESET;
        end else if (ctrl_wr_w) begin
          bank_control_reg[b] <= reg_wdata[3:0];
        end
      end

      // only the bank just closed waits; the other runs at once
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          prech_r[b] <= 3'h0;
        end else if (seg_end_w && mine_w) begin
          prech_r[b] <= prech_load_w;
        end else if (prech_r[b] != 3'h0) begin
          prech_r[b] <= prech_r[b] - 3'h1;
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          ras_hold_r[b] <= 1'b0;
        end else if (enter_row_w && (sel_bank_w == 1'(b))) begin
          ras_hold_r[b] <= 1'b1;
        end else if (seg_end_w && mine_w) begin
          ras_hold_r[b] <= 1'b0;
        end
      end
    end
  endgenerate

  // ========================================================
  // falling edge stage: strobes assert half a clock after arming
  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ras_fall_r <= '0;
      cas_fall_r <= 4'h0;
    end else begin
      ras_fall_r <= ras_hold_r;
      cas_fall_r <= cas_hold_r;
    end
  end

  // ========================================================
  // column strobes, address pins and handshake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cas_hold_r  <= 4'h0;
      dram_addr_r <= '0;
      ts_n_r      <= 1'b1;
      ack_n_r     <= 1'b1;
      busy_r      <= 1'b0;
    end else begin
      if (enter_col_w) begin
        cas_hold_r <= cas_mask_w;
      end else if (seg_end_w) begin
        cas_hold_r <= 4'h0;
      end
      if (enter_row_w || enter_pre_w) begin
        dram_addr_r <= row_w;
      end else if (enter_col_w) begin
        dram_addr_r <= col_w;
      end
      ts_n_r  <= ~(start_w);
      ack_n_r <= ~(state_nxt == ST_ACK);
      busy_r  <= (state_nxt != ST_IDLE);
    end
  end

  // ========================================================
  // data path: writes drive from the column cycle on, reads merge at the end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wsh_r      <= 32'h0;
      rsh_r      <= 32'h0;
      d_oe_r     <= 4'h0;
      rd_data_r  <= 32'h0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= 1'b0;
      if (start_w) begin
        wsh_r <= req_wdata;
        rsh_r <= 32'h0;
      end else if (seg_end_w) begin
        wsh_r <= wb_sum_w[2] ? req_wdata : wr_shifted_w;
        rsh_r <= wb_sum_w[2] ? 32'h0 : rd_merged_w;
      end
      if (enter_col_w && write_r) begin
        d_oe_r <= lane_oe_w;
      end else if (seg_end_w && last_seg_w) begin
        d_oe_r <= 4'h0;
      end
      if (seg_end_w && !write_r && word_done_w) begin
        rd_data_r  <= rd_merged_w;
        rd_valid_r <= 1'b1;
      end
    end
  end

  // ========================================================
  // register port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dram_timing_reg <= `TIM_RESET;
      reg_rdata_r     <= 32'h0;
    end else begin
      if (reg_wr && hit_tim_w) begin
        dram_timing_reg <= reg_wdata[5:0];
      end
      reg_rdata_r <= reg_rd ? rd_mux_w : 32'h0;
    end
  end

  // ========================================================
  // outputs
  assign reg_rdata            = reg_rdata_r;
  assign transfer_start_n     = ts_n_r;
  assign transfer_ack_n       = ack_n_r;
  assign rd_data              = rd_data_r;
  assign rd_valid             = rd_valid_r;
  assign busy                 = busy_r;
  assign dram_addr            = dram_addr_r;
  // assert on the falling edge, negate on the rising edge
  assign ras_n                = ~(ras_hold_r & ras_fall_r);
  assign cas_n                = ~(cas_hold_r & cas_fall_r);
  assign dram_write_indicator = dwi_r;
  assign transfer_size_code   = size_r;
  assign d_out                = wsh_r;
  assign d_oe                 = d_oe_r;

endmodule // dram_normal_mode_sequencer

// *** dram_seq_checker.sv ***
`timescale 1ns/1ps
module dram_seq_checker (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     arst_n,
  // core side
  input wire logic                     req_write,
  input wire dram_seq_pkg::size_code_t req_size,
  input wire logic                     transfer_start_n,
  input wire logic                     transfer_ack_n,
  input wire logic                     busy,
  // dram pins
  input wire logic [18:0]              dram_addr,
  input wire logic [1:0]               ras_n,
  input wire logic [3:0]               cas_n,
  input wire logic                     dram_write_indicator,
  input wire dram_seq_pkg::size_code_t transfer_size_code,
  input wire logic [3:0]               d_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ========================================================
  // access sequencing
  a_row_strobe:  assert property (!transfer_start_n |-> ras_n != 2'h3) else $error("row strobe late");
  a_col_strobe:  assert property (!transfer_start_n |=> cas_n != 4'hF) else $error("column strobe late");
  a_row_col:     assert property (!transfer_start_n |=> $changed(dram_addr)) else $error("no column address");
  a_ack_delay:   assert property ($fell(transfer_start_n) |-> ##2 !transfer_ack_n) else $error("ack late");
  a_strobe_end:  assert property (!transfer_ack_n |=> ras_n == 2'h3 && cas_n == 4'hF) else $error("strobes held");
  a_start_gap:   assert property (!transfer_start_n |=> transfer_start_n [*3]) else $error("start too soon");
  a_write_ind:   assert property (!transfer_start_n |-> dram_write_indicator == !req_write) else $error("write ind");
  a_size_code:   assert property (!transfer_start_n |-> transfer_size_code == req_size) else $error("size code");
  a_bus_release: assert property (!busy |-> d_oe == 4'h0) else $error("data bus driven");
  c_burst: cover property (!transfer_ack_n ##4 !transfer_ack_n);
  c_other_bank: cover property (!transfer_ack_n ##2 !transfer_start_n);
  c_write: cover property (!transfer_start_n && !dram_write_indicator);
endmodule // dram_seq_checker

bind dram_normal_mode_sequencer dram_seq_checker u_chk (.clk(clk), .arst_n(arst_n), .req_write(req_write),
  .req_size(req_size), .transfer_start_n(transfer_start_n), .transfer_ack_n(transfer_ack_n), .busy(busy),
  .dram_addr(dram_addr), .ras_n(ras_n), .cas_n(cas_n), .dram_write_indicator(dram_write_indicator),
  .transfer_size_code(transfer_size_code), .d_oe(d_oe));

// *** dram_seq_map.svh ***
`ifndef DRAM_SEQ_MAP_SVH
`define DRAM_SEQ_MAP_SVH

// ==========================================================
// register offsets (byte addresses on the register port)
`define REG_BANK0_CTRL   4'h0
`define REG_BANK1_CTRL   4'h4
`define REG_TIMING       4'h8
`define REG_STATUS       4'hC

// ==========================================================
// field positions and reset values
`define CTRL_PORT_LSB    0
`define CTRL_PAGE_LSB    2
`define CTRL_RESET       4'h0
`define TIM_RCD_LSB      0
`define TIM_CAS_LSB      2
`define TIM_RP_LSB       4
`define TIM_RESET        6'h00

// ==========================================================
// timing counts and address layout
// whole clocks of precharge before the next row cycle of a burst; the strobe then
// asserts half a clock into that cycle, which makes 1.5 clocks in all
`define RP_BASE_CLKS     3'h1
`define ROW_ADDR_LSB     9
`define DRAM_ADDR_W      19
`define PAGE_TAG_W       23

`endif

// *** dram_seq_pkg.sv ***
package dram_seq_pkg;

  // ========================================================
  // sequencer states, gray coded along the access path except the precharge to row step
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ROW  = 3'h1,
    ST_COL  = 3'h3,
    ST_ACK  = 3'h2,
    ST_PRE  = 3'h6
  } seq_state_t;

  // ========================================================
  // operand size codes as driven on transfer_size_code
  typedef enum logic [1:0] {
    SZ_LONG = 2'h0,
    SZ_BYTE = 2'h1,
    SZ_WORD = 2'h2,
    SZ_LINE = 2'h3
  } size_code_t;

  typedef enum logic [1:0] {
    PORT_32 = 2'h0,
    PORT_8  = 2'h1,
    PORT_16 = 2'h2
  } port_size_t;

  typedef enum logic [1:0] {
    PAGE_512 = 2'h0,
    PAGE_1K  = 2'h1,
    PAGE_2K  = 2'h2
  } page_size_t;

endpackage

// *** lane_steer.sv ***
`timescale 1ns/1ps

module lane_steer (
  // port and operand
  input  wire dram_seq_pkg::port_size_t port_size,
  input  wire dram_seq_pkg::size_code_t op_size,
  // data words
  input  wire logic [31:0]              wr_word,
  input  wire logic [31:0]              rd_word,
  input  wire logic [31:0]              d_in,
  // steering results
  output logic      [3:0]               cas_mask,
  output logic      [3:0]               lane_oe,
  output logic      [2:0]               port_bytes,
  output logic      [4:0]               seg_count,
  output logic      [31:0]              wr_shifted,
  output logic      [31:0]              rd_merged
);
  import dram_seq_pkg::*;

  logic [4:0] op_bytes;
  logic [4:0] segs_raw;

  // ========================================================
  // lanes: narrow ports sit on the top of the data bus
  always_comb begin
    case (port_size)
      PORT_8: begin
        cas_mask   = 4'h1;
        port_bytes = 3'h1;
        wr_shifted = {wr_word[23:0], 8'h00};
        rd_merged  = {rd_word[23:0], d_in[31:24]};
        segs_raw   = op_bytes;
      end
      PORT_16: begin
        cas_mask   = 4'h3;
        port_bytes = 3'h2;
        wr_shifted = {wr_word[15:0], 16'h0000};
        rd_merged  = {rd_word[15:0], d_in[31:16]};
        segs_raw   = op_bytes >> 1;
      end
      default: begin
        cas_mask   = 4'hF;
        port_bytes = 3'h4;
        wr_shifted = wr_word;
        rd_merged  = d_in;
        segs_raw   = op_bytes >> 2;
      end
    endcase
  end

  always_comb begin
    case (op_size)
      SZ_BYTE: op_bytes = 5'h01;
      SZ_WORD: op_bytes = 5'h02;
      SZ_LINE: op_bytes = 5'h10;
      default: op_bytes = 5'h04;
    endcase
  end

  assign lane_oe   = {cas_mask[0], cas_mask[1], cas_mask[2], cas_mask[3]};
  // operand no wider than the port is one nonburst segment
  assign seg_count = (segs_raw == 5'h00) ? 5'h01 : segs_raw;

endmodule // lane_steer

// *** test_dram_normal_mode_sequencer.sv ***
`timescale 1ns/1ps
module test_dram_normal_mode_sequencer;
  import dram_seq_pkg::*;
  localparam logic [31:0] PAT = 32'hA5C3_5A3C;
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, req = 0, req_bank = 0, req_write = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, req_addr = 32'h0000_1200, req_wdata = 32'h0;
  size_code_t req_size = SZ_LONG;
  logic [31:0] reg_rdata, rd_data, d_in, d_out;
  logic [18:0] dram_addr;
  logic [3:0] cas_n, d_oe;
  logic [1:0] ras_n;
  logic transfer_start_n, transfer_ack_n, rd_valid, busy, dram_write_indicator;
  size_code_t transfer_size_code;
  int errors = 0, n_checks = 0, cyc = 0, ack_last = 0;

  dram_normal_mode_sequencer uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .req_bank(req_bank), .req_addr(req_addr),
    .req_write(req_write), .req_size(req_size), .req_wdata(req_wdata), .transfer_start_n(transfer_start_n),
    .transfer_ack_n(transfer_ack_n), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .dram_addr(dram_addr),
    .ras_n(ras_n), .cas_n(cas_n), .dram_write_indicator(dram_write_indicator),
    .transfer_size_code(transfer_size_code), .d_in(d_in), .d_out(d_out), .d_oe(d_oe));
  dram_model #(.PAT(PAT)) mem (.ras_n(ras_n), .cas_n(cas_n), .d_oe(d_oe), .d_in(d_in));

  initial forever #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // ========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_w(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_r(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  // one transfer; hold keeps the request up so the next one follows at once
  task automatic xfer(input logic b, w, nb, hold, input size_code_t s, input logic [31:0] wd, rx,
                      input logic [3:0] cs, input int sh, nseg, gap);
    int t0, acks, tl, rv, k;
    logic [31:0] m, ca;
    // lanes from the strobes: cas_n[0] goes with the top byte
    m = {{8{~cs[0]}}, {8{~cs[1]}}, {8{~cs[2]}}, {8{~cs[3]}}};
    // bank 1 is a 16-bit port with 1K pages, bank 0 an 8-bit port with 512-byte pages
    ca = b ? ((req_addr & 32'h3FF) >> 1) : (req_addr & 32'h1FF);
    acks = 0;
    tl = 0;
    rv = 0;
    k = 0;
    @(posedge clk);
    req <= 1'b1;
    req_bank <= b;
    req_write <= w;
    req_size <= s;
    req_wdata <= wd;
    do begin
      @(negedge clk);
      k++;
    end while (transfer_start_n !== 1'b0 && k < 60);
    t0 = cyc;
    chk(dram_addr, req_addr[27:9]);
    chk(dram_write_indicator, !w);
    chk(transfer_size_code, s);
    if (gap >= 0) chk(t0 - ack_last, gap);
    @(posedge clk);
    req <= hold;
    req_bank <= nb;
    for (k = 0; k < 60 && !(acks == nseg && cyc > ack_last); k++) begin
      @(negedge clk);
      if (transfer_start_n === 1'b0) tl++;
      if (transfer_ack_n === 1'b0) begin
        chk(cyc - (acks == 0 ? t0 : ack_last), acks == 0 ? 2 : 4);
        chk(cas_n, cs);
        chk(dram_addr, ca + acks);
        chk(ras_n, {~b, b});
        chk(d_oe, w ? {~cs[0], ~cs[1], ~cs[2], ~cs[3]} : 4'h0);
        if (w) chk(d_out & m, (wd << (sh * acks)) & m);
        ack_last = cyc;
        acks++;
      end
      if (rd_valid === 1'b1 && !w) begin
        rv++;
        chk(rd_data, rx);
      end
    end
    chk(acks, nseg);
    chk(tl, 0);
    chk(rv, !w);
    chk(d_oe, 4'h0);
  endtask
  // ========================================================
  // scenarios
  task automatic t_regs();
    reg_w(4'h0, 32'h0000_0001);
    reg_w(4'h4, 32'h0000_0006);
    reg_w(4'hE, 32'hFFFF_FFFF);
    reg_r(4'h0, 32'h0000_0001);
    reg_r(4'h4, 32'h0000_0006);
    reg_r(4'h8, 32'h0000_0000);
    reg_r(4'hE, 32'h0000_0000);
  endtask
  task automatic t_byte_reads();
    xfer(0, 0, 0, 1, SZ_BYTE, 0, {24'h0, PAT[31:24]}, 4'hE, 8, 1, -1);
    xfer(0, 0, 0, 0, SZ_BYTE, 0, {24'h0, PAT[31:24]}, 4'hE, 8, 1, 3);
  endtask
  task automatic t_write_bursts();
    xfer(1, 1, 0, 1, SZ_LONG, 32'h1234_ABCD, 0, 4'hC, 16, 2, -1);
    xfer(0, 1, 0, 0, SZ_LONG, 32'h1234_ABCD, 0, 4'hE, 8, 4, 2);
  endtask
  task automatic t_read_sizes();
    xfer(1, 0, 0, 0, SZ_LONG, 0, {PAT[31:16], PAT[31:16]}, 4'hC, 16, 2, -1);
    xfer(1, 0, 0, 0, SZ_WORD, 0, {16'h0, PAT[31:16]}, 4'hC, 16, 1, -1);
  endtask
  task automatic summarize();
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_byte_reads();
    t_write_bursts();
    t_read_sizes();
    summarize();
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule // test_dram_normal_mode_sequencer
